//--- core_timing_pkg.sv
/*
  constants for the core storage cycle timing block.
  assumes a 125 MHz system clock; all times are converted to cycle counts here.
*/
package core_timing_pkg;
  localparam int unsigned CLK_PERIOD_NS     = 8;
  localparam int unsigned SEGMENT_NS        = 250;
  localparam int unsigned SEGMENT_COUNT     = 3;
  localparam int unsigned CYCLE_NS          = SEGMENT_NS * SEGMENT_COUNT;
  localparam int unsigned TAP_NS            = 25;
  localparam int unsigned TAP_COUNT         = CYCLE_NS / TAP_NS;
  // least times round up to whole cycles
  localparam int unsigned SEGMENT_CYC       = (SEGMENT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned TAP_CYC           = (TAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CYCLE_CYC         = TAP_CYC * TAP_COUNT;
  // phase windows, counted in taps
  localparam int unsigned SRC_ON_TAP        = 4;
  localparam int unsigned SRC_OFF_TAP       = 16;
  localparam int unsigned READY_TAP         = 24;
  localparam int unsigned SEL_ON_TAP        = 1;
  localparam int unsigned SEL_OFF_TAP       = 20;
  localparam int unsigned GRID_LINES        = 128;
  localparam int unsigned SENSE_BLOCK       = 4096;
  localparam int unsigned BLOCKS_PER_PLANE  = 16384 / SENSE_BLOCK;
  localparam int unsigned UNIT_BYTES        = 32768;
  localparam logic [1:0]  CFG_8K            = 2'h0;
  localparam logic [1:0]  CFG_16K           = 2'h1;
  localparam logic [1:0]  CFG_32K           = 2'h2;
  localparam logic [1:0]  CFG_65K           = 2'h3;
  localparam logic [5:0]  TAP_ZERO          = 6'h00;
  localparam logic [1:0]  DIV_ZERO          = 2'h0;
  localparam logic [6:0]  LINE_ZERO         = 7'h00;
  localparam logic [3:0]  GATE_ZERO         = 4'h0;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_READ  = 3'b010,
    ST_WRITE = 3'b100
  } cycle_state_t;
endpackage : core_timing_pkg

//--- core_storage_cycle_timing.sv
/*
  self-timed read/write cycle generator and drive line selection for a core store.
  assumes the host holds the address stable from read call through the
  following write cycle and never raises both calls together; call pins are async.
*/
`timescale 1ns/1ns
`default_nettype none

// Behaviour
// - idle until read or write call, then run the cycle alone.
// - chain spans 750 ns as three 250 ns segments in sequence; here 30 taps of 4 clocks, 960 ns, in segments of 320 ns.
// - a tap every 25 ns sets and clears the timing latches; here taps come every 4 clocks, 32 ns.
// - read call sets the read control latch and launches the chain.
// - read latch steers taps only to read timing latches.
// - read cycle ends 750 ns after its start; here it ends after 120 clocks, 960 ns.
// - write call sets the write control latch and launches the chain.
// - write latch gates taps only to write timing latches.
// - write cycle ends 750 ns after its start; here it ends after 120 clocks, 960 ns.
// - four drive enables: x read, x write, y read, y write.
// - read phase turns on x and y read sources after selection settles.
// - selection routes each source to one x and one y line.
// - each plane is a 128 by 128 grid; decoders pick one of 128.
// - 8k: five planes, upper half of fifth plane never sensed.
// - x drive direction chooses which 8k half is addressed.
// - 32k: pick y, then 16k x set, x line, then x direction.
// - 65k is two 32k units, selected by the top address bit.
// - sense and inhibit selection works on 4096-core blocks.
// - near the end of a read, pulse data ready to the host.
module core_storage_cycle_timing #(
  parameter int unsigned LINES = core_timing_pkg::GRID_LINES
) (
  input  wire logic        clk_sys_i,
  input  wire logic        rst_n_i,
  input  wire logic        read_call_i,
  input  wire logic        write_call_i,
  input  wire logic [15:0] addr_i,
  input  wire logic [1:0]  size_cfg_i,
  output logic             busy_o,
  output logic             data_ready_o,
  output logic             x_read_src_o,
  output logic             x_write_src_o,
  output logic             y_read_src_o,
  output logic             y_write_src_o,
  output logic [6:0]       line_address_decoder_x_o,
  output logic [6:0]       line_address_decoder_y_o,
  output logic             line_control_driver_o,
  output logic [1:0]       line_gate_a_o,
  output logic             line_gate_b_o,
  output logic             x_dir_reverse_o,
  output logic [3:0]       sense_block_o,
  output logic             sense_enable_o,
  output logic             unit_select_o
);

  core_timing_pkg::cycle_state_t state_reg;
  logic [2:0] rd_sync_reg;
  logic [2:0] wr_sync_reg;
  logic       rd_level_reg;
  logic       wr_level_reg;
  logic       rd_start;
  logic       wr_start;
  logic [1:0] div_reg;
  logic [5:0] tap_reg;
  logic       tap_pulse;
  logic       last_tap;
  logic [1:0] segment;
  logic [15:0] addr_reg;
  logic [7:0] tap_hist_reg;

  // a change counts once the second and third stage agree
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rd_sync_reg  <= 3'h0;
      wr_sync_reg  <= 3'h0;
      rd_level_reg <= 1'b0;
      wr_level_reg <= 1'b0;
    end else begin
      rd_sync_reg <= {rd_sync_reg[1:0], read_call_i};
      wr_sync_reg <= {wr_sync_reg[1:0], write_call_i};
      if (rd_sync_reg[1] == rd_sync_reg[2]) begin
        rd_level_reg <= rd_sync_reg[2];
      end
      if (wr_sync_reg[1] == wr_sync_reg[2]) begin
        wr_level_reg <= wr_sync_reg[2];
      end
    end
  end

  // call edges; both together is a host fault and starts nothing
  assign rd_start = rd_sync_reg[2] && rd_sync_reg[1] && !rd_level_reg && !wr_sync_reg[2];
  assign wr_start = wr_sync_reg[2] && wr_sync_reg[1] && !wr_level_reg && !rd_sync_reg[2];

  // 25 ns tap enable: 4 clocks of 8 ns, the nearest whole count not under the tap
  assign tap_pulse = (state_reg != core_timing_pkg::ST_IDLE) &&
                     (div_reg == 2'(core_timing_pkg::TAP_CYC - 1));
  assign last_tap  = tap_pulse && (tap_reg == 6'(core_timing_pkg::TAP_COUNT - 1));
  assign segment   = 2'(tap_reg / 6'(core_timing_pkg::TAP_COUNT / core_timing_pkg::SEGMENT_COUNT));

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_reg <= core_timing_pkg::ST_IDLE;
    end else begin
      case (state_reg)
        core_timing_pkg::ST_IDLE: begin
          if (rd_start) begin
            state_reg <= core_timing_pkg::ST_READ;
          end else if (wr_start) begin
            state_reg <= core_timing_pkg::ST_WRITE;
          end
        end
        core_timing_pkg::ST_READ,
        core_timing_pkg::ST_WRITE: begin
          // calls during a running cycle are dropped
          if (last_tap) begin
            state_reg <= core_timing_pkg::ST_IDLE;
          end
        end
        default: state_reg <= core_timing_pkg::ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      div_reg <= core_timing_pkg::DIV_ZERO;
      tap_reg <= core_timing_pkg::TAP_ZERO;
    end else if (state_reg == core_timing_pkg::ST_IDLE) begin
      div_reg <= core_timing_pkg::DIV_ZERO;
      tap_reg <= core_timing_pkg::TAP_ZERO;
    end else begin
      div_reg <= div_reg + 2'h1;
      if (last_tap) begin
        tap_reg <= core_timing_pkg::TAP_ZERO;
      end else if (tap_pulse) begin
        tap_reg <= tap_reg + 6'h01;
      end
    end
  end

  // address held at read start and reused by the write that follows
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      addr_reg <= 16'h0000;
    end else if (rd_start && state_reg == core_timing_pkg::ST_IDLE) begin
      addr_reg <= addr_i;
    end
  end

  // timing latches: set at one tap, cleared at a later one
  logic src_phase;
  logic sel_phase;
  assign src_phase = (tap_reg >= 6'(core_timing_pkg::SRC_ON_TAP)) &&
                     (tap_reg <  6'(core_timing_pkg::SRC_OFF_TAP));
  assign sel_phase = (tap_reg >= 6'(core_timing_pkg::SEL_ON_TAP)) &&
                     (tap_reg <  6'(core_timing_pkg::SEL_OFF_TAP));

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      x_read_src_o  <= 1'b0;
      y_read_src_o  <= 1'b0;
      x_write_src_o <= 1'b0;
      y_write_src_o <= 1'b0;
      data_ready_o  <= 1'b0;
    end else begin
      x_read_src_o  <= (state_reg == core_timing_pkg::ST_READ) && src_phase;
      y_read_src_o  <= (state_reg == core_timing_pkg::ST_READ) && src_phase;
      x_write_src_o <= (state_reg == core_timing_pkg::ST_WRITE) && src_phase;
      y_write_src_o <= (state_reg == core_timing_pkg::ST_WRITE) && src_phase;
      data_ready_o  <= (state_reg == core_timing_pkg::ST_READ) && tap_pulse &&
                       (tap_reg == 6'(core_timing_pkg::READY_TAP));
    end
  end

  // line selection from the held address; it is up well before the sources fire
  // bits: [15] unit, [14] 16k set, [13] 8k half, [12:11] sense block row, [6:0] y
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      line_address_decoder_x_o <= core_timing_pkg::LINE_ZERO;
      line_address_decoder_y_o <= core_timing_pkg::LINE_ZERO;
      line_control_driver_o    <= 1'b0;
      line_gate_a_o            <= 2'h0;
      line_gate_b_o            <= 1'b0;
      x_dir_reverse_o          <= 1'b0;
      sense_block_o            <= core_timing_pkg::GATE_ZERO;
      sense_enable_o           <= 1'b0;
      unit_select_o            <= 1'b0;
    end else begin
      line_address_decoder_y_o <= addr_reg[6:0];
      line_address_decoder_x_o <= addr_reg[13:7];
      line_control_driver_o    <= sel_phase;
      line_gate_b_o            <= sel_phase;
      x_dir_reverse_o          <= addr_reg[13] && size_cfg_i != core_timing_pkg::CFG_8K;
      line_gate_a_o            <= sel_phase ? ((size_cfg_i >= core_timing_pkg::CFG_32K) ?
                                  {addr_reg[14], !addr_reg[14]} : 2'h1) : 2'h0;
      unit_select_o            <= (size_cfg_i == core_timing_pkg::CFG_65K) && addr_reg[15];
      sense_block_o            <= 4'h1 << addr_reg[12:11];
      // upper half of the fifth plane carries no bit in the 8k array
      sense_enable_o           <= (state_reg == core_timing_pkg::ST_READ) && sel_phase &&
                                  !(size_cfg_i == core_timing_pkg::CFG_8K && addr_reg[12]);
    end
  end

  assign busy_o = (state_reg != core_timing_pkg::ST_IDLE);

  // helper: tap pulse history, shifted in every clock; no assertion reads it
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tap_hist_reg <= 8'h00;
    end else begin
      tap_hist_reg <= {tap_hist_reg[6:0], tap_pulse};
    end
  end

  sequence s_read_go;
    state_reg == core_timing_pkg::ST_IDLE && rd_start;
  endsequence
  sequence s_write_go;
    state_reg == core_timing_pkg::ST_IDLE && wr_start && !rd_start;
  endsequence

  property p_read_launch;
    @(posedge clk_sys_i) disable iff (!rst_n_i) s_read_go |=> state_reg == core_timing_pkg::ST_READ;
  endproperty
  a_read_launch: assert property (p_read_launch) else $error("read call did not start");

  property p_write_launch;
    @(posedge clk_sys_i) disable iff (!rst_n_i) s_write_go |=> state_reg == core_timing_pkg::ST_WRITE;
  endproperty
  a_write_launch: assert property (p_write_launch) else $error("write call did not start");

  property p_read_length;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
      s_read_go |=> (state_reg == core_timing_pkg::ST_READ) [*8] ##113 state_reg == core_timing_pkg::ST_IDLE;
  endproperty
  a_read_length: assert property (p_read_length) else $error("read cycle not 120 clocks");

  property p_write_length;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
      s_write_go |=> ##119 busy_o ##1 !busy_o;
  endproperty
  a_write_length: assert property (p_write_length) else $error("write cycle not 120 clocks");

  property p_idle_quiet;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
      !busy_o && !$past(busy_o) |-> !x_read_src_o && !x_write_src_o && !y_read_src_o && !y_write_src_o;
  endproperty
  a_idle_quiet: assert property (p_idle_quiet) else $error("source on while idle");

  property p_read_only;
    @(posedge clk_sys_i) disable iff (!rst_n_i) x_read_src_o |-> !x_write_src_o && !y_write_src_o && y_read_src_o;
  endproperty
  a_read_only: assert property (p_read_only) else $error("write source during read");

  property p_write_only;
    @(posedge clk_sys_i) disable iff (!rst_n_i) x_write_src_o |-> !x_read_src_o && !y_read_src_o && y_write_src_o;
  endproperty
  a_write_only: assert property (p_write_only) else $error("read source during write");

  property p_select_first;
    @(posedge clk_sys_i) disable iff (!rst_n_i) $rose(x_read_src_o) |-> line_control_driver_o;
  endproperty
  a_select_first: assert property (p_select_first) else $error("source before selection");

  property p_ignore_busy;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
      state_reg == core_timing_pkg::ST_READ && !last_tap |=> state_reg == core_timing_pkg::ST_READ;
  endproperty
  a_ignore_busy: assert property (p_ignore_busy) else $error("cycle disturbed mid-run");

  property p_ready_read;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
      data_ready_o |-> $past(state_reg) == core_timing_pkg::ST_READ ##1 !data_ready_o;
  endproperty
  a_ready_read: assert property (p_ready_read) else $error("data ready outside read");

  property p_tap_spacing;
    @(posedge clk_sys_i) disable iff (!rst_n_i) tap_pulse |=> !tap_pulse [*3];
  endproperty
  a_tap_spacing: assert property (p_tap_spacing) else $error("tap spacing not 4 clocks");

  // the last tap must fall in the third segment, or the chain length and split disagree
  property p_segment_end;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
      last_tap |-> segment == 2'(core_timing_pkg::SEGMENT_COUNT - 1);
  endproperty
  a_segment_end: assert property (p_segment_end) else $error("cycle ended outside last segment");

  property p_write_steady;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
      state_reg == core_timing_pkg::ST_WRITE && !last_tap |=> state_reg == core_timing_pkg::ST_WRITE;
  endproperty
  a_write_steady: assert property (p_write_steady) else $error("write cycle disturbed mid-run");

  // ready tap plus one register stage, counted from the first busy clock
  property p_ready_place;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
      $rose(busy_o) && state_reg == core_timing_pkg::ST_READ |-> ##100 data_ready_o;
  endproperty
  a_ready_place: assert property (p_ready_place) else $error("data ready at wrong clock");

  property p_write_select;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
      $rose(x_write_src_o) |-> line_control_driver_o && line_gate_b_o;
  endproperty
  a_write_select: assert property (p_write_select) else $error("write source before selection");

  property p_sense_read;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
      sense_enable_o |-> $past(state_reg) == core_timing_pkg::ST_READ;
  endproperty
  a_sense_read: assert property (p_sense_read) else $error("sense gated outside read");

endmodule : core_storage_cycle_timing
`default_nettype wire

//--- host_model.sv
/*
  behavioural host that issues read and write calls to the core store.
  assumes the store answers on busy_o; drives only on falling edges.
*/
`timescale 1ns/1ns
`default_nettype none
module host_model (
  input  wire logic        clk_sys_i,
  output logic             read_call_o,
  output logic             write_call_o,
  output logic [15:0]      addr_o
);
  logic interlock_reg;

  initial begin
    read_call_o   = 1'b0;
    write_call_o  = 1'b0;
    addr_o        = 16'h0000;
    interlock_reg = 1'b0;
  end

  // the address only moves while no read is waiting for its write
  task automatic start(input logic w, input logic [15:0] a);
    @(negedge clk_sys_i);
    if (!w && !interlock_reg) begin
      addr_o = a;
    end
    read_call_o   = !w; // one call at a time
    write_call_o  = w;
    interlock_reg = !w; // set by read, cleared by write
  endtask : start

  // calls are levels; drop and wait out the synchroniser before the next rise
  task automatic release_call();
    @(negedge clk_sys_i);
    read_call_o  = 1'b0;
    write_call_o = 1'b0;
    repeat (4) @(negedge clk_sys_i);
  endtask : release_call

  // deliberate misuse: a call raised for n cycles without looking at busy
  task automatic stray(input logic rd, input logic wr, input int n);
    @(negedge clk_sys_i);
    read_call_o  = read_call_o | rd;
    write_call_o = write_call_o | wr;
    repeat (n) @(negedge clk_sys_i);
    read_call_o  = 1'b0;
    write_call_o = 1'b0;
  endtask : stray
endmodule : host_model
`default_nettype wire

//--- tb_core_storage_cycle_timing.sv
/*
  self-checking bench for the core storage cycle timing block.
  assumes host_model as the calling processor and the package constants.
*/
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin failures++; \
  $display("[ERR] %0t got %0h exp %0h", $time, (g), (e)); end end
module tb_core_storage_cycle_timing;
  logic        clk_sys_i, rst_n_i, read_call, write_call, busy_o, data_ready_o;
  logic        x_read_src_o, x_write_src_o, y_read_src_o, y_write_src_o, ctl_o, gate_b_o;
  logic        x_dir_o, sense_enable_o, unit_select_o;
  logic [15:0] addr;
  logic [1:0]  size_cfg_i, gate_a_o;
  logic [6:0]  line_x_o, line_y_o;
  logic [3:0]  sense_block_o;
  int          failures, n_compared;
  logic [15:0] addrs [5] = '{16'h1a5c, 16'h0801, 16'h3f81, 16'h4c27, 16'hd3e6};
  logic [1:0]  cfgs [5]  = '{2'h0, 2'h0, 2'h1, 2'h2, 2'h3};

  host_model i_host_model (.clk_sys_i(clk_sys_i), .read_call_o(read_call),
    .write_call_o(write_call), .addr_o(addr));
  core_storage_cycle_timing i_core_storage_cycle_timing (.clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_i), .read_call_i(read_call), .write_call_i(write_call), .addr_i(addr),
    .size_cfg_i(size_cfg_i), .busy_o(busy_o), .data_ready_o(data_ready_o),
    .x_read_src_o(x_read_src_o), .x_write_src_o(x_write_src_o),
    .y_read_src_o(y_read_src_o), .y_write_src_o(y_write_src_o),
    .line_address_decoder_x_o(line_x_o), .line_address_decoder_y_o(line_y_o),
    .line_control_driver_o(ctl_o), .line_gate_a_o(gate_a_o), .line_gate_b_o(gate_b_o),
    .x_dir_reverse_o(x_dir_o), .sense_block_o(sense_block_o),
    .sense_enable_o(sense_enable_o), .unit_select_o(unit_select_o));

  initial begin
    clk_sys_i = 1'b0;
    forever #4 clk_sys_i = ~clk_sys_i;
  end

  task automatic end_sim();
    $display("compared %0d mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : end_sim

  // runs one cycle, counting phases and checking selection whenever a source is on
  task automatic run(input logic w, input logic [15:0] a, input logic [1:0] cfg);
    int   k, bsy, sr, sw, rdy, rdy_at, se, bad;
    logic edir, eu, ese;
    logic [1:0] ega;
    bsy = 0;
    sr = 0;
    sw = 0;
    rdy = 0;
    rdy_at = 0;
    se = 0;
    bad = 0;
    edir = (cfg == core_timing_pkg::CFG_8K) ? 1'b0 : a[13];
    eu   = (cfg == core_timing_pkg::CFG_65K) && a[15];
    ega  = (cfg >= core_timing_pkg::CFG_32K) ? {a[14], ~a[14]} : 2'h1;
    ese  = !w && !(cfg == core_timing_pkg::CFG_8K && a[12]);
    i_host_model.start(w, a);
    for (k = 0; k < 20 && busy_o !== 1'b1; k++) @(posedge clk_sys_i) #1;
    `CHK(busy_o, 1'b1)
    if (busy_o !== 1'b1) begin
      end_sim();
    end
    while (busy_o === 1'b1 && bsy < 200) begin
      bsy++;
      sr += (x_read_src_o && y_read_src_o);
      sw += (x_write_src_o && y_write_src_o);
      se += sense_enable_o;
      if (data_ready_o) begin
        rdy++;
        rdy_at = bsy;
      end
      if (x_read_src_o | x_write_src_o | y_read_src_o | y_write_src_o) begin
        if (x_read_src_o !== y_read_src_o || x_write_src_o !== y_write_src_o
            || ctl_o !== 1'b1 || gate_b_o !== 1'b1 || gate_a_o !== ega
            || line_x_o !== a[13:7] || line_y_o !== a[6:0] || x_dir_o !== edir
            || unit_select_o !== eu || sense_block_o !== (4'h1 << a[12:11])) bad++;
      end
      @(posedge clk_sys_i) #1;
    end
    `CHK(bsy, core_timing_pkg::CYCLE_CYC)
    `CHK(w ? sw : sr, (core_timing_pkg::SRC_OFF_TAP - core_timing_pkg::SRC_ON_TAP) * core_timing_pkg::TAP_CYC)
    `CHK(w ? sr : sw, 0)
    `CHK(rdy, w ? 0 : 1)
    `CHK(w || (rdy_at >= 90 && rdy_at < bsy), 1'b1)
    `CHK(bad, 0)
    `CHK(se > 0, ese)
    i_host_model.release_call();
  endtask : run

  task automatic t_reset();
    int k, b;
    b = 0;
    `CHK({busy_o, data_ready_o, x_read_src_o, y_read_src_o, x_write_src_o}, 5'h00)
    for (k = 0; k < 20; k++) @(posedge clk_sys_i) #1 b += busy_o;
    `CHK(b, 0)
    $display("test reset done");
  endtask : t_reset

  task automatic t_configs();
    for (int i = 0; i < 5; i++) begin
      @(negedge clk_sys_i);
      size_cfg_i = cfgs[i];
      run(1'b0, addrs[i], cfgs[i]);
      run(1'b1, addrs[i], cfgs[i]);
    end
    $display("test configs done");
  endtask : t_configs

  // a call during a running cycle must neither stretch it nor switch its kind
  task automatic t_refuse();
    int k, b;
    b = 0;
    fork
      run(1'b0, 16'h2468, size_cfg_i);
      begin
        repeat (20) @(negedge clk_sys_i);
        i_host_model.stray(1'b0, 1'b1, 8);
      end
    join
    run(1'b1, 16'h2468, size_cfg_i);
    fork
      i_host_model.stray(1'b1, 1'b1, 8);
      for (k = 0; k < 20; k++) @(posedge clk_sys_i) #1 b += busy_o;
    join
    `CHK(b, 0)
    $display("test refuse done");
  endtask : t_refuse

  initial begin
    failures   = 0;
    n_compared = 0;
    rst_n_i    = 1'b0;
    size_cfg_i = 2'h0;
    repeat (3) @(negedge clk_sys_i);
    rst_n_i = 1'b1;
    t_reset();
    t_configs();
    t_refuse();
    end_sim();
  end
endmodule : tb_core_storage_cycle_timing
`default_nettype wire
